// *** tb/oam_loopback_result_status_bench.sv ***
// Self-checking bench for the loop-back result and status register bank.
// Assumes the far-end model drives the event inputs and the fibre link state.
`timescale 1ns/1ps

module oam_loopback_result_status_bench
    import olr_pkg::*;
;
    localparam logic [1:0] HW = 2'h2; // Arbitrary value.
    logic i_clk;
    logic i_rst;
    logic i_reg_wr;
    logic i_reg_rd;
    logic i_center_side;
    logic [7:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic [7:0] o_reg_rdata;
    logic [4:0] evt;
    logic link_dn;
    logic [1:0] o_model_sel;
    logic [1:0] o_remote_cmd_reserved_hi;
    olr_opcode_t o_remote_cmd_opcode;
    olr_opmode_t o_remote_cmd_opmode;
    logic o_use_remote_cmd;
    int n_mismatch;
    int total_checks;

    olr_regs #(.HW_VERSION(HW)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_center_side(i_center_side), .i_lb_timeout_evt(evt[0]), .i_lb_good_evt(evt[1]),
        .i_stop_ind_evt(evt[2]), .i_loop_dur_expired_evt(evt[3]), .i_reply_wait_expired_evt(evt[4]),
        .i_fibre_link_down(link_dn), .o_model_sel(o_model_sel), .o_remote_cmd_opcode(o_remote_cmd_opcode),
        .o_remote_cmd_opmode(o_remote_cmd_opmode), .o_use_remote_cmd(o_use_remote_cmd),
        .o_remote_cmd_reserved_hi(o_remote_cmd_reserved_hi)
    );

    olr_far_model far (.i_clk(i_clk), .o_evt(evt), .o_link_down(link_dn));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic results;
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    // Read data is sampled a full cycle after the taking edge; it holds until the next read.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        chk(o_reg_rdata, exp);
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        results;
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        i_rst = 1'b1;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_center_side = 1'b1;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        rdchk(8'h47, 8'h00);
        rdchk(8'h48, 8'h00);
        rdchk(8'h49, {HW, 6'h00});
        rdchk(8'h4A, 8'h22);
        rdchk(8'h50, 8'h00);
        // Counting, writes to read-only counters, clear only on a zero setup write.
        far.fire(0, 3);
        far.fire(1, 5);
        wr(8'h47, 8'h55);
        wr(8'h48, 8'hAA);
        wr(8'h44, 8'h07);
        rdchk(8'h47, 8'h03);
        rdchk(8'h48, 8'h05);
        wr(8'h44, 8'h00);
        rdchk(8'h47, 8'h00);
        rdchk(8'h48, 8'h00);
        fork
            far.fire(0, 260);
            far.fire(1, 258);
        join
        rdchk(8'h47, 8'hFF);
        rdchk(8'h48, 8'hFF);
        wr(8'h44, 8'h00);
        // A terminal-side bank ignores all events.
        i_center_side <= 1'b0;
        far.fire(0, 2);
        far.fire(2, 1);
        rdchk(8'h47, 8'h00);
        rdchk(8'h49, {HW, 6'h00});
        i_center_side <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            far.fire(k + 2, 1);
            rdchk(8'h49, {HW, 2'b00, 4'h8 >> k});
            rdchk(8'h49, {HW, 6'h00});
        end
        far.set_link(1'b1);
        repeat (3) @(posedge i_clk);
        rdchk(8'h49, {HW, 6'h01});
        far.set_link(1'b0);
        repeat (3) @(posedge i_clk);
        rdchk(8'h49, {HW, 6'h00});
        // Model field is writable; version and flag bits are not.
        wr(8'h49, 8'h1F);
        rdchk(8'h49, {HW, 6'h10});
        chk({6'h00, o_model_sel}, 8'h01);
        wr(8'h49, 8'hC0);
        rdchk(8'h49, {HW, 6'h00});
        for (int op = 0; op < 4; op++) begin
            wr(8'h4A, {2'b00, 2'b11, op[1:0], 2'b10});
            rdchk(8'h4A, {2'b00, 2'b10, op[1:0], 2'b10});
            chk({6'h00, o_remote_cmd_opcode}, {6'h00, op[1:0]});
        end
        for (int m = 0; m < 4; m++) begin
            wr(8'h4A, {4'h2, 2'b00, m[1:0]});
            rdchk(8'h4A, {4'h2, 2'b00, m[1:0]});
            chk({6'h00, o_remote_cmd_opmode}, {6'h00, m[1:0]});
            chk({7'h00, o_use_remote_cmd}, {7'h00, m == 2});
        end
        chk({6'h00, o_remote_cmd_reserved_hi}, 8'h00);
        // A reset in mid-run restores every default.
        wr(8'h49, 8'h10);
        far.fire(0, 4);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rdchk(8'h47, 8'h00);
        rdchk(8'h49, {HW, 6'h00});
        rdchk(8'h4A, 8'h22);
        results;
    end
endmodule

// *** tb/olr_far_model.sv ***
// Behavioural far-end converter: raises maintenance events and moves the fibre link state.
// Assumes the bench calls its tasks and that events share the bank's clock.
`timescale 1ns/1ps

module olr_far_model (
    input wire logic i_clk,
    output logic [4:0] o_evt,
    output logic o_link_down
);
    // Event bits: 0 timeout, 1 good return, 2 stop indication, 3 loop expiry, 4 reply expiry.
    initial begin
        o_evt = 5'h00;
        o_link_down = 1'b0;
    end

    // --------------------------------------------------------------
    // Event pulses
    // --------------------------------------------------------------
    // Holds event k high for n cycles, so back-to-back events reach the bank.
    task automatic fire(input int k, input int n);
        @(posedge i_clk);
        o_evt[k] <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_evt[k] <= 1'b0;
    endtask

    // The link state moves off the clock edge, since it comes from another domain.
    task automatic set_link(input logic v);
        @(posedge i_clk);
        #7;
        o_link_down = v;
    endtask
endmodule

// *** verilog/olr_cnt_if.sv ***
// Control and value lines between the register bank and one result counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface olr_cnt_if;
    logic clr;
    logic inc;
    logic [7:0] count;

    modport ctl (output clr, output inc, input count);
    modport cnt (input clr, input inc, output count);
endinterface

// *** verilog/olr_map.svh ***
// Register offsets, field positions and reset values of the loop-back result and status bank.
// Included by the design modules; definitions only.
`ifndef OLR_MAP_SVH
`define OLR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets on the management port
// ----------------------------------------------------------------
`define OLR_OFF_LB_SETUP 8'h44
`define OLR_OFF_TIMEOUT_CNT 8'h47
`define OLR_OFF_GOOD_CNT 8'h48
`define OLR_OFF_ADD_STATUS 8'h49
`define OLR_OFF_REMOTE_CMD1 8'h4A

// ----------------------------------------------------------------
// Values and reset states
// ----------------------------------------------------------------
`define OLR_LB_CLEAR_VAL 8'h00
`define OLR_CNT_ZERO 8'h00
`define OLR_CNT_ONE 8'h01
`define OLR_CNT_MAX 8'hFF
`define OLR_RST_MODEL 2'h0
`define OLR_RST_OPCODE 2'h0
`define OLR_RST_OPMODE 2'h2
`define OLR_RST_RSV_HI 2'h0
`define OLR_CAP_EXTENDED 2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OLR_STS_LINK_BIT 0
`define OLR_STS_REPLY_BIT 1
`define OLR_STS_DUR_BIT 2
`define OLR_STS_STOP_BIT 3
`define OLR_STS_MODEL_LSB 4
`define OLR_STS_HWVER_LSB 6
`define OLR_RC_OPMODE_LSB 0
`define OLR_RC_OPCODE_LSB 2
`define OLR_RC_CAP_LSB 4
`define OLR_RC_RSV_LSB 6

`endif

// *** verilog/olr_pkg.sv ***
// Types shared by the loop-back result and status bank.
// Assumes olr_map.svh is on the include path.
package olr_pkg;

    typedef enum logic [1:0] {
        olr_mode_normal = 2'b00,
        olr_mode_rsv_a = 2'b01,
        olr_mode_extended = 2'b10,
        olr_mode_rsv_b = 2'b11
    } olr_opmode_t;

    typedef enum logic [1:0] {
        olr_op_read_reply = 2'b00,
        olr_op_read_req = 2'b01,
        olr_op_write_reply = 2'b10,
        olr_op_write_req = 2'b11
    } olr_opcode_t;

endpackage

// *** verilog/olr_regs.sv ***
// Loop-back result counters, additional status and first remote-command register.
// Assumes the management port strobes are one-cycle pulses on i_clk and that the
// event inputs come from maintenance logic on the same clock; the fibre link
// state arrives from another domain and is synchronised here.
`timescale 1ns/1ps
`include "olr_map.svh"

module olr_regs
    import olr_pkg::*;
#(
    parameter logic [1:0] HW_VERSION = 2'h2 // Arbitrary value.
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_center_side,
    input wire logic i_lb_timeout_evt,
    input wire logic i_lb_good_evt,
    input wire logic i_stop_ind_evt,
    input wire logic i_loop_dur_expired_evt,
    input wire logic i_reply_wait_expired_evt,
    input wire logic i_fibre_link_down,
    output logic [1:0] o_model_sel,
    output olr_opcode_t o_remote_cmd_opcode,
    output olr_opmode_t o_remote_cmd_opmode,
    output logic o_use_remote_cmd,
    output logic [1:0] o_remote_cmd_reserved_hi
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic wr_setup_zero;
    logic wr_status;
    logic wr_remote;
    logic rd_status;

    assign wr_setup_zero = i_reg_wr && hit(i_reg_addr, `OLR_OFF_LB_SETUP) && (i_reg_wdata == `OLR_LB_CLEAR_VAL);
    assign wr_status = i_reg_wr && hit(i_reg_addr, `OLR_OFF_ADD_STATUS);
    assign wr_remote = i_reg_wr && hit(i_reg_addr, `OLR_OFF_REMOTE_CMD1);
    assign rd_status = i_reg_rd && hit(i_reg_addr, `OLR_OFF_ADD_STATUS);

    // ----------------------------------------------------------------
    // Result counters
    // ----------------------------------------------------------------
    olr_cnt_if cnt_if[2] ();
    logic [1:0] cnt_evt;

    assign cnt_evt[0] = i_center_side && i_lb_timeout_evt;
    assign cnt_evt[1] = i_center_side && i_lb_good_evt;

    generate
        for (genvar g = 0; g < 2; g++) begin : g_cnt
            assign cnt_if[g].clr = wr_setup_zero;
            assign cnt_if[g].inc = cnt_evt[g];
            olr_sat_counter u_cnt (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .bus(cnt_if[g])
            );
        end
    endgenerate

    logic [7:0] timeout_cnt;
    logic [7:0] good_cnt;

    assign timeout_cnt = cnt_if[0].count;
    assign good_cnt = cnt_if[1].count;

    // ----------------------------------------------------------------
    // Link state synchroniser
    // ----------------------------------------------------------------
    logic link_s1_r;
    logic link_s2_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            link_s1_r <= 1'b0;
            link_s2_r <= 1'b0;
        end else begin
            link_s1_r <= i_fibre_link_down;
            link_s2_r <= link_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Status flags and control fields
    // ----------------------------------------------------------------
    logic stop_flag_r;
    logic stop_flag_nxt;
    logic dur_flag_r;
    logic dur_flag_nxt;
    logic reply_flag_r;
    logic reply_flag_nxt;
    logic [1:0] model_r;
    logic [1:0] model_nxt;
    logic [1:0] rsv_hi_r;
    logic [1:0] rsv_hi_nxt;
    olr_opcode_t opcode_r;
    olr_opcode_t opcode_nxt;
    olr_opmode_t opmode_r;
    olr_opmode_t opmode_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] status_val;
    logic [7:0] remote_val;

    assign status_val = {HW_VERSION, model_r, stop_flag_r, dur_flag_r, reply_flag_r, link_s2_r};
    assign remote_val = {rsv_hi_r, `OLR_CAP_EXTENDED, opcode_r, opmode_r};

    // A flag event in the reading cycle wins over the clear, so it is seen next read.
    always_comb begin
        stop_flag_nxt = (i_center_side && i_stop_ind_evt) || (stop_flag_r && !rd_status);
        dur_flag_nxt = (i_center_side && i_loop_dur_expired_evt) || (dur_flag_r && !rd_status);
        reply_flag_nxt = (i_center_side && i_reply_wait_expired_evt) || (reply_flag_r && !rd_status);
        model_nxt = model_r;
        rsv_hi_nxt = rsv_hi_r;
        opcode_nxt = opcode_r;
        opmode_nxt = opmode_r;
        if (wr_status) begin
            model_nxt = i_reg_wdata[`OLR_STS_MODEL_LSB +: 2];
        end
        if (wr_remote) begin
            rsv_hi_nxt = i_reg_wdata[`OLR_RC_RSV_LSB +: 2];
            opcode_nxt = olr_opcode_t'(i_reg_wdata[`OLR_RC_OPCODE_LSB +: 2]);
            opmode_nxt = olr_opmode_t'(i_reg_wdata[`OLR_RC_OPMODE_LSB +: 2]);
        end
        rdata_nxt = rdata_r;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `OLR_OFF_TIMEOUT_CNT: begin
                    rdata_nxt = timeout_cnt;
                end
                `OLR_OFF_GOOD_CNT: begin
                    rdata_nxt = good_cnt;
                end
                `OLR_OFF_ADD_STATUS: begin
                    rdata_nxt = status_val;
                end
                `OLR_OFF_REMOTE_CMD1: begin
                    rdata_nxt = remote_val;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stop_flag_r <= 1'b0;
            dur_flag_r <= 1'b0;
            reply_flag_r <= 1'b0;
            model_r <= `OLR_RST_MODEL;
            rsv_hi_r <= `OLR_RST_RSV_HI;
            opcode_r <= olr_opcode_t'(`OLR_RST_OPCODE);
            opmode_r <= olr_opmode_t'(`OLR_RST_OPMODE);
            rdata_r <= 8'h00;
        end else begin
            stop_flag_r <= stop_flag_nxt;
            dur_flag_r <= dur_flag_nxt;
            reply_flag_r <= reply_flag_nxt;
            model_r <= model_nxt;
            rsv_hi_r <= rsv_hi_nxt;
            opcode_r <= opcode_nxt;
            opmode_r <= opmode_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Reserved bits are passed out as written; the frame logic is expected to ignore them.
    assign o_reg_rdata = rdata_r;
    assign o_model_sel = model_r;
    assign o_remote_cmd_opcode = opcode_r;
    assign o_remote_cmd_opmode = opmode_r;
    assign o_use_remote_cmd = (opmode_r == olr_mode_extended);
    assign o_remote_cmd_reserved_hi = rsv_hi_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_read_status;
        rd_status;
    endsequence

    sequence s_quiet_flags;
        !i_stop_ind_evt && !i_loop_dur_expired_evt && !i_reply_wait_expired_evt;
    endsequence

    sequence s_write_remote_ext;
        wr_remote && i_reg_wdata[1:0] == 2'b10;
    endsequence

    a_tmo_count_inc: assert property (
        (cnt_evt[0] && !wr_setup_zero && timeout_cnt != `OLR_CNT_MAX) |=> (timeout_cnt == 8'($past(timeout_cnt) + 8'h01)))
        else $error("Timeout counter did not step on a timeout.");

    a_good_count_hold: assert property (
        (good_cnt == `OLR_CNT_MAX && !wr_setup_zero) |=> (good_cnt == `OLR_CNT_MAX))
        else $error("Good counter wrapped past its top value.");

    a_clear_counts: assert property (
        (wr_setup_zero && !cnt_evt[0] && !cnt_evt[1]) |=> (timeout_cnt == 8'h00 && good_cnt == 8'h00))
        else $error("Counters not cleared by a zero setup write.");

    a_stop_flag_set: assert property (
        (i_center_side && i_stop_ind_evt) |=> stop_flag_r ##1 (o_reg_rdata[3] || !$past(rd_status)))
        else $error("Stop indication flag not set or not reported.");

    a_flag_read_clear: assert property (
        (s_read_status and s_quiet_flags) |=> (!stop_flag_r && !dur_flag_r && !reply_flag_r))
        else $error("Status flags survived a read.");

    a_reply_flag_set: assert property (
        (i_center_side && i_reply_wait_expired_evt) |=> reply_flag_r)
        else $error("Reply-wait flag not set.");

    a_link_sync: assert property (
        i_fibre_link_down [*3] |-> link_s2_r)
        else $error("Link down not shown after two stages.");

    a_version_field: assert property (
        s_read_status |=> (o_reg_rdata[7:6] == HW_VERSION && o_reg_rdata[0] == $past(link_s2_r)))
        else $error("Status read shows wrong version or link bit.");

    a_model_write: assert property (
        wr_status |=> (o_model_sel == $past(i_reg_wdata[5:4])))
        else $error("Model field not taken from write.");

    a_capability: assert property (
        (i_reg_rd && hit(i_reg_addr, `OLR_OFF_REMOTE_CMD1)) |=> (o_reg_rdata[5:4] == 2'b10))
        else $error("Capability field does not read 10.");

    a_opmode_select: assert property (
        s_write_remote_ext |=> (o_use_remote_cmd ##1 (o_use_remote_cmd || $past(wr_remote))))
        else $error("Extended mode not selected after write.");

    a_opcode_write: assert property (
        wr_remote |=> (o_remote_cmd_opcode == $past(i_reg_wdata[3:2])))
        else $error("Operating code not taken from write.");

endmodule

// *** verilog/olr_sat_counter.sv ***
// Eight-bit saturating result counter with synchronous clear.
// Assumes clear and count requests come from logic on i_clk.
`timescale 1ns/1ps
`include "olr_map.svh"

module olr_sat_counter
    import olr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    olr_cnt_if.cnt bus
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // A count that lands in the clearing cycle is kept, so no event is lost.
    always_comb begin
        cnt_nxt = cnt_r;
        if (bus.clr) begin
            cnt_nxt = bus.inc ? `OLR_CNT_ONE : `OLR_CNT_ZERO;
        end else if (bus.inc && cnt_r != `OLR_CNT_MAX) begin
            cnt_nxt = 8'(cnt_r + 8'h01);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= `OLR_CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign bus.count = cnt_r;

    a_cnt_hold_max: assert property (@(posedge i_clk) disable iff (i_rst)
        (cnt_r == `OLR_CNT_MAX && !bus.clr) |=> (cnt_r == `OLR_CNT_MAX))
        else $error("Counter left its top value without a clear.");

    a_cnt_clear_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (bus.clr && !bus.inc) |=> (cnt_r == `OLR_CNT_ZERO))
        else $error("Counter not zero after clear.");

endmodule
